// File: hw/hmpc_consts.vh
// constants for the halt mode power controller
`ifndef HMPC_CONSTS_VH
`define HMPC_CONSTS_VH
// register offsets (byte addresses)
`define HMPC_ADDR_AWCS     8'h2b
`define HMPC_ADDR_AWPR     8'h2c
`define HMPC_ADDR_MCCS     8'h30
`define HMPC_ADDR_OPT      8'h31
`define HMPC_ADDR_STAT     8'h32
// auto-wake control/status fields
`define HMPC_AWCS_EN       0
`define HMPC_AWCS_MEAS     1
`define HMPC_AWCS_FLAG     2
// main clock control/status field
`define HMPC_MCCS_OIE      0
// option field positions
`define HMPC_OPT_LONG      0
`define HMPC_OPT_WATCHDOG_HALT_OPTION   1
`define HMPC_OPT_WDGEN     2
// reset values
`define HMPC_AWPR_RST      8'hff
// halt opcode
`define HMPC_HALT_OPCODE   8'h8e
// stabilisation delays in cpu cycles
`define HMPC_STAB_SHORT    13'd256
`define HMPC_STAB_LONG     13'd4096
// fixed rc divider
`define HMPC_RC_FIXDIV     64
// forced interrupt mask value
`define HMPC_IMASK_HALT    2'b10
`endif

// File: hw/hmpc_sync3.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hmpc_sync3
(
   input  wire mclk_i,    // main clock
   input  wire rstn_i,    // async reset, active low
   input  wire async_i,   // raw input
   output reg  sync_o     // filtered level
);
   reg s1_r;
   reg s2_r;
   reg s3_r;

   ////////////////////////////////////////////////////////////////
   // first stage feeds only the second
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s1_r   <= 1'b0;
         s2_r   <= 1'b0;
         s3_r   <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         s1_r <= async_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // change counts once stages two and three agree
         if (s2_r == s3_r)
            sync_o <= s3_r;
      end
   end
endmodule // hmpc_sync3

// File: hw/hmpc_stab_cnt.v
// loadable down counter for oscillator stabilisation
`timescale 1ns/1ps
`include "hmpc_consts.vh"
module hmpc_stab_cnt
(
   input  wire mclk_i,    // main clock
   input  wire rstn_i,    // async reset, active low
   input  wire start_i,   // load pulse
   input  wire long_i,    // 1 selects the long delay
   output wire busy_o,    // counting
   output wire done_o     // one-cycle pulse at expiry
);
   reg [12:0] cnt_r;
   reg        busy_r;

   assign busy_o = busy_r;
   assign done_o = busy_r && (cnt_r == 13'd1);

   ////////////////////////////////////////////////////////////////
   // R21 load and count down
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_r  <= 13'd0;
         busy_r <= 1'b0;
      end
      else if (start_i)
      begin
         cnt_r  <= long_i ? `HMPC_STAB_LONG : `HMPC_STAB_SHORT;
         busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
         cnt_r <= cnt_r - 13'd1;
         if (cnt_r == 13'd1)
            busy_r <= 1'b0;
      end
   end
endmodule // hmpc_stab_cnt

// File: hw/hmpc_top.v
// halt mode power controller: halt, active-halt, auto-wake
// Halt mode rules for this block, the core and software
// R1 - halt opcode with both enables clear enters plain halt
// R2 - halt opcode with oscillator irq enable only enters active-halt
// R3 - halt opcode with auto-wake enable only enters auto-wake halt
// R4 - plain halt exit restarts oscillator and waits 256 or 4096 cycles
// R5 - any halt entry forces interrupt mask bits to 10b
// R6 - plain and auto-wake halt stop oscillator and all clocks except the auto-wake rc
// R7 - watchdog on and halt disallowed: halt opcode raises watchdog reset
// R8 - active-halt keeps only oscillator and real-time counter running
// R9 - active-halt exit by rtc, irq or reset; delay only on reset
// R10 - active-halt never gives a watchdog reset on halt opcode
// R11 - auto-wake starts rc oscillator, fixed divider then 8-bit prescaler
// R12 - auto-wake expiry sets flag, raises irq, restarts oscillator, waits
// R13 - reading auto-wake control/status clears flag and its interrupt
// R14 - measure bit in run mode enables rc and routes it to capture one
// R15 - core stacks condition code and sets priority before servicing wake irq
// R16 - auto-wake mode left on halt-exit interrupt or reset like halt
// R17 - opcode 0x8e is decoded as the halt instruction
// R18 - software may clear pending interrupts before halting
// R19 - auto-wake time is 64 times prescaler rc periods plus start-up
// R20 - prescaler 00h ignored on write; 01h to ffh divide by 1 to 255
// R21 - stabilisation counted by counter loaded with 256 or 4096
`timescale 1ns/1ps
`include "hmpc_consts.vh"
module hmpc_top
(
   input  wire       mclk_i,           // main oscillator clock
   input  wire       rstn_i,           // async reset, active low
   input  wire [7:0] addr_i,           // register address
   input  wire [7:0] wdata_i,          // register write data
   input  wire       wr_i,             // write strobe
   input  wire       rd_i,             // read strobe
   output reg  [7:0] rdata_o,          // read data, cycle after strobe
   input  wire [7:0] opcode_i,         // opcode being executed
   input  wire       opcode_vld_i,     // opcode execute strobe
   input  wire       wake_irq_i,       // halt-exit capable interrupt pending
   input  wire       rtc_irq_i,        // real-time counter interrupt
   input  wire       wake_rc_clock_i,  // rc oscillator clock, async
   input  wire       rc_ready_i,       // rc oscillator started, async
   output wire       osc_enable_o,     // main oscillator enable
   output wire       core_clk_en_o,    // core clock gate
   output wire       periph_clk_en_o,  // peripheral clock gate
   output wire       rtc_clk_en_o,     // real-time counter clock gate
   output wire       rc_enable_o,      // rc oscillator enable
   output wire       timer_capture_input_one_o, // rc clock to timer capture
   output reg        imask_force_o,    // force condition code mask pulse
   output wire [1:0] imask_val_o,      // mask value to force
   output reg        wdg_reset_o,      // watchdog reset request pulse
   output wire       auto_wake_irq_o,  // auto-wake interrupt
   output wire       wake_done_o       // core released after wake pulse
);
   // one-hot states
   localparam [4:0] ST_RUN   = 5'b00001;
   localparam [4:0] ST_HALT  = 5'b00010;
   localparam [4:0] ST_AHALT = 5'b00100;
   localparam [4:0] ST_AWU   = 5'b01000;
   localparam [4:0] ST_STAB  = 5'b10000;

   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg       boot_r;              // stabilisation after reset pending
   reg       osc_irq_enable_r;
   reg       auto_wake_enable_r;
   reg       auto_wake_measure_r;
   reg       auto_wake_flag_r;
   reg [7:0] auto_wake_prescaler_r;
   reg       opt_long_r;
   reg       watchdog_halt_option_r;
   reg       wdg_enable_r;
   reg [5:0] fix_cnt_r;
   reg [7:0] pre_cnt_r;
   reg       rc_prev_r;
   reg       awu_expire_r;

   wire rc_sync;
   wire rc_rdy_sync;
   wire stab_busy;
   wire stab_done;
   wire halt_op;
   wire halt_ok;
   wire stab_start;
   wire rc_rise;

   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   hmpc_sync3 u_sync_rc
   (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .async_i (wake_rc_clock_i),
      .sync_o  (rc_sync)
   );

   hmpc_sync3 u_sync_rdy
   (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .async_i (rc_ready_i),
      .sync_o  (rc_rdy_sync)
   );

   hmpc_stab_cnt u_stab
   (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .start_i (stab_start),
      .long_i  (opt_long_r),
      .busy_o  (stab_busy),
      .done_o  (stab_done)
   );

   ////////////////////////////////////////////////////////////////
   // R17 halt opcode decode
   assign halt_op = opcode_vld_i && (opcode_i == `HMPC_HALT_OPCODE) && state_r[0] && !boot_r;
   // R7 halt refused when watchdog on and option disallows it, except R10 active-halt entry
   assign halt_ok = (osc_irq_enable_r && !auto_wake_enable_r) || !(wdg_enable_r && !watchdog_halt_option_r);

   // rc rising edge seen on the filtered level, never the first stage
   assign rc_rise = rc_sync && !rc_prev_r;

   ////////////////////////////////////////////////////////////////
   // mode state machine
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN:
         begin
            if (halt_op && halt_ok)
            begin
               // R1 both enables clear
               if (!osc_irq_enable_r && !auto_wake_enable_r)
                  state_nxt = ST_HALT;
               // R2 oscillator irq enable only
               else if (osc_irq_enable_r && !auto_wake_enable_r)
                  state_nxt = ST_AHALT;
               // R3 auto-wake only
               else if (!osc_irq_enable_r && auto_wake_enable_r)
                  state_nxt = ST_AWU;
               else
                  state_nxt = ST_HALT;
            end
         end
         // R4 plain halt wakes via stabilisation
         ST_HALT:
            if (wake_irq_i)
               state_nxt = ST_STAB;
         // R9 active-halt exit by irq is immediate
         ST_AHALT:
            if (wake_irq_i || rtc_irq_i)
               state_nxt = ST_RUN;
         // R16 interrupt or R12 expiry leaves auto-wake
         ST_AWU:
            if (wake_irq_i || awu_expire_r)
               state_nxt = ST_STAB;
         ST_STAB:
            if (stab_done)
               state_nxt = ST_RUN;
         default:
            state_nxt = ST_RUN;
      endcase
   end

   // oscillator restart from stopped states loads the counter;
   // reset exit loads it once, else the core would never be released
   assign stab_start = ((state_r[1] || state_r[3]) && state_nxt[4]) ||
                       (boot_r && state_r[4] && !stab_busy);

   ////////////////////////////////////////////////////////////////
   // state register; reset exit of every halt state goes through boot delay
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_r <= ST_STAB;
         boot_r  <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         // R9 reset exit delay also counted here
         if (boot_r && state_r[4] && stab_done)
            boot_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // R5 mask force on any halt-class entry; R7 R10 watchdog reset
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         imask_force_o <= 1'b0;
         wdg_reset_o   <= 1'b0;
      end
      else
      begin
         imask_force_o <= state_r[0] && !state_nxt[0];
         wdg_reset_o   <= halt_op && !halt_ok;
      end
   end
   assign imask_val_o = `HMPC_IMASK_HALT;

   ////////////////////////////////////////////////////////////////
   // R6 R8 clock gating
   assign osc_enable_o    = !(state_r[1] || state_r[3]);
   assign core_clk_en_o   = state_r[0];
   assign periph_clk_en_o = state_r[0];
   assign rtc_clk_en_o    = state_r[0] || state_r[2];
   // R11 R14 rc runs in auto-wake or while measuring in run
   assign rc_enable_o     = state_r[3] || (state_r[0] && auto_wake_measure_r);
   assign timer_capture_input_one_o = state_r[0] && auto_wake_measure_r && rc_sync;
   assign auto_wake_irq_o = auto_wake_flag_r;
   // R15 core may service the irq once released
   assign wake_done_o     = state_r[4] && stab_done;

   ////////////////////////////////////////////////////////////////
   // R11 R19 fixed divide by 64 then prescaler, after rc start-up
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         fix_cnt_r    <= 6'd0;
         pre_cnt_r    <= 8'd0;
         rc_prev_r    <= 1'b0;
         awu_expire_r <= 1'b0;
      end
      else
      begin
         rc_prev_r <= rc_sync;
         if (!state_r[3])
         begin
            fix_cnt_r    <= 6'd0;
            pre_cnt_r    <= auto_wake_prescaler_r;
            awu_expire_r <= 1'b0;
         end
         else if (rc_rdy_sync && rc_rise && !awu_expire_r)
         begin
            fix_cnt_r <= fix_cnt_r + 6'd1;
            if (fix_cnt_r == 6'd63)
            begin
               if (pre_cnt_r == 8'd1)
                  awu_expire_r <= 1'b1;
               else
                  pre_cnt_r <= pre_cnt_r - 8'd1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // register writes and flag
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         osc_irq_enable_r       <= 1'b0;
         auto_wake_enable_r     <= 1'b0;
         auto_wake_measure_r    <= 1'b0;
         auto_wake_flag_r       <= 1'b0;
         auto_wake_prescaler_r  <= `HMPC_AWPR_RST;
         opt_long_r             <= 1'b1;
         watchdog_halt_option_r <= 1'b1;
         wdg_enable_r           <= 1'b0;
      end
      else
      begin
         if (wr_i)
         begin
            if (addr_i == `HMPC_ADDR_AWCS)
            begin
               auto_wake_enable_r  <= wdata_i[`HMPC_AWCS_EN];
               auto_wake_measure_r <= wdata_i[`HMPC_AWCS_MEAS];
            end
            // R20 zero prescaler write ignored
            else if (addr_i == `HMPC_ADDR_AWPR)
            begin
               if (wdata_i != 8'h00)
                  auto_wake_prescaler_r <= wdata_i;
            end
            else if (addr_i == `HMPC_ADDR_MCCS)
               osc_irq_enable_r <= wdata_i[`HMPC_MCCS_OIE];
            else if (addr_i == `HMPC_ADDR_OPT)
            begin
               opt_long_r             <= wdata_i[`HMPC_OPT_LONG];
               watchdog_halt_option_r <= wdata_i[`HMPC_OPT_WATCHDOG_HALT_OPTION];
               wdg_enable_r           <= wdata_i[`HMPC_OPT_WDGEN];
            end
         end
         // R12 set wins over R13 read clear
         if (awu_expire_r && state_r[3])
            auto_wake_flag_r <= 1'b1;
         else if (rd_i && addr_i == `HMPC_ADDR_AWCS)
            auto_wake_flag_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // read data, one cycle after strobe, zero otherwise
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rdata_o <= 8'h00;
      else if (!rd_i)
         rdata_o <= 8'h00;
      else if (addr_i == `HMPC_ADDR_AWCS)
         rdata_o <= {5'h00, auto_wake_flag_r, auto_wake_measure_r, auto_wake_enable_r};
      else if (addr_i == `HMPC_ADDR_AWPR)
         rdata_o <= auto_wake_prescaler_r;
      else if (addr_i == `HMPC_ADDR_MCCS)
         rdata_o <= {7'h00, osc_irq_enable_r};
      else if (addr_i == `HMPC_ADDR_OPT)
         rdata_o <= {5'h00, wdg_enable_r, watchdog_halt_option_r, opt_long_r};
      else if (addr_i == `HMPC_ADDR_STAT)
         rdata_o <= {2'b00, stab_busy, state_r};
      else
         rdata_o <= 8'h00;
   end
endmodule // hmpc_top

// File: tb/hmpc_checker.sv
// assertion checker for the halt mode power controller ports
`timescale 1ns/1ps
`include "hmpc_consts.vh"
module hmpc_checker
(
   input wire logic       mclk_i,          // main clock
   input wire logic       rstn_i,          // async reset, active low
   input wire logic [7:0] addr_i,          // register address
   input wire logic [7:0] wdata_i,         // register write data
   input wire logic       wr_i,            // write strobe
   input wire logic       rd_i,            // read strobe
   input wire logic [7:0] opcode_i,        // executed opcode
   input wire logic       opcode_vld_i,    // opcode strobe
   input wire logic       osc_enable_o,    // oscillator enable
   input wire logic       core_clk_en_o,   // core clock gate
   input wire logic       periph_clk_en_o, // peripheral gate
   input wire logic       rtc_clk_en_o,    // real-time counter gate
   input wire logic       rc_enable_o,     // rc oscillator enable
   input wire logic       imask_force_o,   // mask force pulse
   input wire logic [1:0] imask_val_o,     // forced mask value
   input wire logic       wdg_reset_o,     // watchdog reset pulse
   input wire logic       auto_wake_irq_o, // auto-wake interrupt
   input wire logic       wake_done_o      // stabilisation end pulse
);
   reg        oie_r, awen_r, meas_r, long_r, wdok_r, wden_r;
   reg [12:0] stab_r;
   wire       hlt  = opcode_vld_i && opcode_i == `HMPC_HALT_OPCODE && core_clk_en_o;
   wire       refd = wden_r && !wdok_r && !(oie_r && !awen_r);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   ////////////////////////////////////////////////////////////
   // shadow control bits, so halt outcomes can be predicted
   always @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         {oie_r, awen_r, meas_r, long_r, wdok_r, wden_r} <= 6'b000110;
      else if (wr_i)
      begin
         if (addr_i == `HMPC_ADDR_MCCS) oie_r <= wdata_i[0];
         if (addr_i == `HMPC_ADDR_AWCS) {meas_r, awen_r} <= wdata_i[1:0];
         if (addr_i == `HMPC_ADDR_OPT) {wden_r, wdok_r, long_r} <= wdata_i[2:0];
      end
   // cycles spent with oscillator on but nothing clocked; saturates
   always @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i)
         stab_r <= 13'h0000;
      else if (osc_enable_o && !rtc_clk_en_o && !core_clk_en_o)
         stab_r <= stab_r + {12'h000, stab_r != 13'h1fff};
      else
         stab_r <= 13'h0000;
   ////////////////////////////////////////////////////////////
   property p_plain; hlt && !oie_r && !refd |=> !osc_enable_o && !core_clk_en_o && !periph_clk_en_o
      && !rtc_clk_en_o; endproperty
   a_plain: assert property (p_plain) else $error("plain halt left clocks running");
   property p_active; hlt && oie_r && !awen_r |=> osc_enable_o && rtc_clk_en_o && !core_clk_en_o
      && !periph_clk_en_o; endproperty
   a_active: assert property (p_active) else $error("active halt clocks wrong");
   property p_nowdg; hlt && oie_r && !awen_r |=> !wdg_reset_o; endproperty
   a_nowdg: assert property (p_nowdg) else $error("watchdog reset in active halt");
   property p_awake; hlt && awen_r && !oie_r && !refd |=> rc_enable_o && !osc_enable_o; endproperty
   a_awake: assert property (p_awake) else $error("auto-wake entry wrong");
   property p_mask; hlt && !refd |=> imask_force_o && imask_val_o == `HMPC_IMASK_HALT; endproperty
   a_mask: assert property (p_mask) else $error("mask not forced on halt entry");
   property p_wdg; hlt && refd |=> wdg_reset_o && core_clk_en_o; endproperty
   a_wdg: assert property (p_wdg) else $error("refused halt gave no watchdog reset");
   property p_stab; wake_done_o && stab_r != 13'h0000 |-> stab_r >= (long_r ? 13'd4093 : 13'd253)
      && stab_r <= (long_r ? 13'd4099 : 13'd259); endproperty
   a_stab: assert property (p_stab) else $error("stabilisation length wrong");
   property p_flag; rd_i && addr_i == `HMPC_ADDR_AWCS && auto_wake_irq_o |=> ##1 !auto_wake_irq_o; endproperty
   a_flag: assert property (p_flag) else $error("flag survived a status read");
   property p_meas; core_clk_en_o |-> rc_enable_o == meas_r; endproperty
   a_meas: assert property (p_meas) else $error("rc enable differs from measure bit");
endmodule // hmpc_checker
bind hmpc_top hmpc_checker u_chk (.mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .opcode_i, .opcode_vld_i,
   .osc_enable_o, .core_clk_en_o, .periph_clk_en_o, .rtc_clk_en_o, .rc_enable_o, .imask_force_o, .imask_val_o,
   .wdg_reset_o, .auto_wake_irq_o, .wake_done_o);

// File: tb/hmpc_rc_osc.sv
// behavioural rc wake-up oscillator beside the controller
`timescale 1ns/1ps
module hmpc_rc_osc
#(
   parameter HALF_NS  = 100,  // half period of the rc clock
   parameter START_NS = 1000  // start-up time before ready
)
(
   input  wire logic en_i,   // enable from the controller
   output logic      clk_o,  // rc clock, low while stopped
   output logic      rdy_o   // oscillator started
);
   ////////////////////////////////////////////////////////////
   // runs only when enabled
   // stands low when stopped so no stale edge reaches the prescaler
   initial
   begin
      clk_o = 1'b0;
      rdy_o = 1'b0;
      forever
      begin
         wait (en_i === 1'b1);
         #START_NS rdy_o = 1'b1;
         while (en_i === 1'b1)
         begin
            #HALF_NS clk_o = ~clk_o;
         end
         clk_o = 1'b0;
         rdy_o = 1'b0;
      end
   end
endmodule // hmpc_rc_osc

// File: tb/hmpc_top_tb.sv
// testbench for the halt mode power controller
`timescale 1ns/1ps
module hmpc_top_tb;
   logic       mclk_i = '0, rstn_i = '0, wr_i = '0, rd_i = '0, opcode_vld_i = '0, wake_irq_i = '0, rtc_irq_i = '0;
   logic [7:0] addr_i = '0, wdata_i = '0, opcode_i = '0;
   wire  [7:0] rdata_o;
   wire  [1:0] imask_val_o;
   wire        osc_enable_o, core_clk_en_o, periph_clk_en_o, rtc_clk_en_o, rc_enable_o, imask_force_o;
   wire        timer_capture_input_one_o, wdg_reset_o, auto_wake_irq_o, wake_done_o, wake_rc_clock_i, rc_ready_i;
   int         err_count = 0, n_checks = 0, n, t;
   ////////////////////////////////////////////////////////////
   // 25 MHz main clock
   always #20 mclk_i = ~mclk_i;
   hmpc_top dut (.mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .opcode_i, .opcode_vld_i,
      .wake_irq_i, .rtc_irq_i, .wake_rc_clock_i, .rc_ready_i, .osc_enable_o, .core_clk_en_o, .periph_clk_en_o,
      .rtc_clk_en_o, .rc_enable_o, .timer_capture_input_one_o, .imask_force_o, .imask_val_o, .wdg_reset_o,
      .auto_wake_irq_o, .wake_done_o);
   hmpc_rc_osc u_rc (.en_i(rc_enable_o), .clk_o(wake_rc_clock_i), .rdy_o(rc_ready_i));
   ////////////////////////////////////////////////////////////
   // clock gates packed as osc, core, periph, rtc, rc
   function automatic logic [7:0] clks();
      return {3'h0, osc_enable_o, core_clk_en_o, periph_clk_en_o, rtc_clk_en_o, rc_enable_o};
   endfunction
   function automatic logic sig(input int s);
      return s == 0 ? wake_done_o : s == 1 ? auto_wake_irq_o : core_clk_en_o;
   endfunction
   task automatic end_of_test();
      if (err_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         err_count++;
      end
   endtask
   task automatic rng(input string nm, input int v, input int lo, input int hi);
      chk(nm, {7'h0, v >= lo && v <= hi}, 8'h01);
   endtask
   // one-cycle bus strobes, data sampled in the cycle after a read
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk("rdata", rdata_o, e);
   endtask
   task automatic op(input logic [7:0] c);
      @(posedge mclk_i);
      opcode_i <= c;
      opcode_vld_i <= 1'b1;
      @(posedge mclk_i);
      opcode_vld_i <= 1'b0;
      #1;
   endtask
   // bounded wait; a hang counts as a mismatch
   task automatic wait_on(input int s, output int k);
      k = 0;
      while (sig(s) !== 1'b1 && k < 6000)
      begin
         @(posedge mclk_i);
         #1 k++;
      end
      if (k >= 6000)
      begin
         err_count++;
         end_of_test();
      end
   endtask
   ////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (5) @(posedge mclk_i);
      rstn_i <= 1'b1;
      op(8'h8e);
      chk("boot clocks", clks(), 8'h10);
      wait_on(0, n);
      rng("boot delay", n, 4088, 4100);
      rd(8'h2b, 8'h00);
      rd(8'h2c, 8'hff);
      rd(8'h31, 8'h03);
      rd(8'h40, 8'h00);
      chk("run clocks", clks(), 8'h1e);
      wr(8'h31, 8'h00);
      wr(8'h2c, 8'h00);
      rd(8'h2c, 8'hff);
      wr(8'h2c, 8'h02);
      rd(8'h2c, 8'h02);
      op(8'h8f);
      chk("other opcode", clks(), 8'h1e);
      op(8'h8e);
      chk("halt clocks", clks(), 8'h00);
      wake_irq_i <= 1'b1;
      wait_on(0, n);
      rng("halt exit", n, 250, 262);
      wake_irq_i <= 1'b0;
      wr(8'h30, 8'h01);
      op(8'h8e);
      chk("active clocks", clks(), 8'h12);
      rtc_irq_i <= 1'b1;
      wait_on(2, n);
      rng("rtc exit", n, 1, 4);
      rtc_irq_i <= 1'b0;
      op(8'h8e);
      chk("active again", clks(), 8'h12);
      rstn_i <= 1'b0;
      repeat (5) @(posedge mclk_i);
      rstn_i <= 1'b1;
      wait_on(0, n);
      rng("reset exit", n, 4088, 4100);
      wr(8'h31, 8'h04);
      op(8'h8e);
      chk("wdg pulse", {7'h0, wdg_reset_o}, 8'h01);
      chk("wdg run", clks(), 8'h1e);
      wr(8'h30, 8'h01);
      op(8'h8e);
      chk("no wdg", {7'h0, wdg_reset_o}, 8'h00);
      wake_irq_i <= 1'b1;
      wait_on(2, n);
      rng("irq exit", n, 1, 4);
      wake_irq_i <= 1'b0;
      wr(8'h30, 8'h00);
      wr(8'h31, 8'h00);
      wr(8'h2c, 8'h02);
      wr(8'h2b, 8'h01);
      op(8'h8e);
      chk("awake clocks", clks(), 8'h01);
      wait_on(1, n);
      rng("awake time", n, 660, 1200);
      wait_on(0, n);
      rng("awake stab", n, 250, 262);
      rd(8'h2b, 8'h05);
      rd(8'h2b, 8'h01);
      wr(8'h2b, 8'h02);
      chk("measure clocks", clks(), 8'h1f);
      t = 0;
      repeat (100)
      begin
         @(posedge mclk_i);
         #1 t += int'(timer_capture_input_one_o === 1'b1);
      end
      rng("capture", t, 10, 90);
      wr(8'h2b, 8'h00);
      chk("measure off", clks(), 8'h1e);
      end_of_test();
   end
endmodule // hmpc_top_tb
